// ===== hdl/cpps_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpps_params.svh"

// Overview of operation
// - Charge needs inhibit low, supply over lockout, adapter, rail over cell.
// - Also needs no overvoltage, 700 ms plus 10 ms, regulators ready.
// - Blocked by thermal shutdown, thermistor fault, low ratio ref, learn.
// - At power-up or without adapter, battery switch on, adapter switch off.
// - 700 ms after detection, with input above cell, move load to adapter.
// - Both switches off for 10 us before the adapter switch closes.
// - On removal wait for input near cell, adapter off, 10 us, battery on.
// - Gate off pulls to rail, gate on holds 6 V below rail.
// - Learn low: selector follows adapter presence.
// - Learn high: adapter off, battery on, charging stopped.
// - Cell low during learn: battery switch off, adapter switch on.
// - Soft-start raises current target in 8 steps of about 1 ms.
// - Buck switches at fixed 300 kHz, duty from error versus ramp.
// - Zero duty allowed; full duty held up to 99.98 percent effective.
// - Bootstrap low over 3 cycles: high side off, low-side refresh pulse.
// - Non-synchronous below sync threshold, synchronous otherwise.
// - Synchronous: low side on when high side off, 30 ns dead time.
// - Non-synchronous: low side on about 80 ns after dead time, then off.
// - Undercurrent checked each cycle, 13 mV fall, 8 mV rise hysteresis.
// - Adapter detected when detect input passes 2.4 V; delays start there.
// - Overvoltage: no charging, adapter off, battery on, no latching.
// - Cell recovers with learn still high: back to battery.
module cpps_top
  import cpps_pkg::*;
#(
  parameter int CUR_W      = 8,
  parameter int DETECT_CYC = `CPPS_DETECT_MS * `CPPS_CLK_MHZ * 1000,
  parameter int INRUSH_CYC = `CPPS_INRUSH_MS * `CPPS_CLK_MHZ * 1000,
  parameter int STEP_CYC   = `CPPS_STEP_MS * `CPPS_CLK_MHZ * 1000
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire cpps_sense_s             sense_pins,
  input  wire logic [`CPPS_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output cpps_gate_s                   gates,
  output logic                         charge_enable,
  output logic      [CUR_W-1:0]        charge_current_target,
  output logic                         sync_mode
);

  localparam int BBM_CYC     = `CPPS_BBM_US * `CPPS_CLK_MHZ;
  localparam int PERIOD_CYC  = `CPPS_CLK_MHZ * 1000 / `CPPS_PWM_KHZ;
  localparam int DEAD_CYC    = (`CPPS_DEAD_NS * `CPPS_CLK_MHZ + 999) / 1000;
  localparam int REFRESH_CYC = (`CPPS_REFRESH_NS * `CPPS_CLK_MHZ + 999)
                               / 1000;
  localparam int QUAL_CYC    = DETECT_CYC + INRUSH_CYC;
  localparam int SENSE_W     = $bits(cpps_sense_s);
  localparam int QUAL_W      = $clog2(QUAL_CYC + 1);
  localparam int STEP_W      = $clog2(STEP_CYC + 1);
  localparam int BBM_W       = $clog2(BBM_CYC + 1);
  localparam int PER_W       = $clog2(PERIOD_CYC + 1);
  localparam int SS_W        = $clog2(`CPPS_SS_STEPS + 1);
  localparam int BOOT_W      = $clog2(`CPPS_BOOT_CYCLES + 2);

  // Two-flop synchronisers; the first stage feeds nothing but the second
  logic [SENSE_W-1:0] sync_meta;
  logic [SENSE_W-1:0] sync_hold;
  cpps_sense_s        sense;

  genvar gi;
  generate
    for (gi = 0; gi < SENSE_W; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          sync_meta[gi] <= 1'b0;
          sync_hold[gi] <= 1'b0;
        end else begin
          sync_meta[gi] <= sense_pins[gi];
          sync_hold[gi] <= sync_meta[gi];
        end
      end
    end
  endgenerate

  assign sense = cpps_sense_s'(sync_hold);

  // Register file
  logic [CUR_W-1:0] prog_current;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prog_current <= CUR_W'(`CPPS_CTRL_RST);
    end else if (reg_wr && reg_addr == `CPPS_CTRL_OFS) begin
      prog_current <= reg_wdata[CUR_W-1:0];
    end
  end

  // Detection timer: counts from the detect edge, saturates at 710 ms
  logic [QUAL_W-1:0] qual_cnt;
  logic              detect_done;
  logic              qual_done;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      qual_cnt <= '0;
    end else if (!sense.adapter_detect) begin
      qual_cnt <= '0;
    end else if (qual_cnt != QUAL_W'(QUAL_CYC)) begin
      qual_cnt <= qual_cnt + 1'b1;
    end
  end

  assign detect_done = qual_cnt >= QUAL_W'(DETECT_CYC);
  assign qual_done   = qual_cnt == QUAL_W'(QUAL_CYC);

  // Power-path selector
  cpps_sel_e        sel_state;
  logic [BBM_W-1:0] bbm_cnt;
  logic             learn_hold;
  logic             want_adapter;
  logic             drop_adapter;
  logic             adapter_on;
  logic             battery_on;

  // Learn keeps the battery on unless the cell has run low
  assign learn_hold = sense.learn_request &&
                      !sense.cell_stack_low;

  assign want_adapter = detect_done && sense.adapter_above_cell &&
                        sense.supply_above_lockout &&
                        !sense.input_overvoltage_flag &&
                        !learn_hold;

  // Removal waits for the rail to sag; overvoltage and learn act at once
  assign drop_adapter = sense.input_overvoltage_flag || learn_hold ||
                        (!sense.adapter_detect &&
                         !sense.adapter_above_cell);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_state <= CPPS_SEL_BATTERY;
      bbm_cnt   <= '0;
    end else begin
      case (sel_state)
        CPPS_SEL_BATTERY: begin
          bbm_cnt <= '0;
          if (want_adapter) begin
            sel_state <= CPPS_SEL_BREAK_TO_ADAPTER;
          end
        end
        CPPS_SEL_BREAK_TO_ADAPTER: begin
          if (!want_adapter) begin
            sel_state <= CPPS_SEL_BREAK_TO_BATTERY;
            bbm_cnt   <= '0;
          end else if (bbm_cnt == BBM_W'(BBM_CYC - 1)) begin
            sel_state <= CPPS_SEL_ADAPTER;
          end else begin
            bbm_cnt <= bbm_cnt + 1'b1;
          end
        end
        CPPS_SEL_ADAPTER: begin
          bbm_cnt <= '0;
          if (drop_adapter) begin
            sel_state <= CPPS_SEL_BREAK_TO_BATTERY;
          end
        end
        CPPS_SEL_BREAK_TO_BATTERY: begin
          if (bbm_cnt == BBM_W'(BBM_CYC - 1)) begin
            sel_state <= CPPS_SEL_BATTERY;
            bbm_cnt   <= '0;
          end else begin
            bbm_cnt <= bbm_cnt + 1'b1;
          end
        end
        default: begin
          sel_state <= CPPS_SEL_BATTERY;
          bbm_cnt   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      adapter_on <= 1'b0;
      battery_on <= 1'b1;
    end else begin
      adapter_on <= sel_state == CPPS_SEL_ADAPTER;
      battery_on <= sel_state == CPPS_SEL_BATTERY;
    end
  end

  // Charge qualification
  logic charge_ok;

  assign charge_ok = !sense.charge_inhibit_n &&
                     sense.supply_above_lockout &&
                     sense.adapter_detect &&
                     sense.adapter_above_cell &&
                     !sense.input_overvoltage_flag &&
                     qual_done && sense.regulators_ready &&
                     !sense.thermal_shutdown_flag &&
                     sense.thermistor_in_window &&
                     sense.ratio_reference_ok &&
                     !sense.learn_request;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      charge_enable <= 1'b0;
    end else begin
      charge_enable <= charge_ok;
    end
  end

  // Soft-start stepper
  logic [SS_W-1:0]   ss_step;
  logic [STEP_W-1:0] step_cnt;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !charge_ok) begin
      ss_step  <= '0;
      step_cnt <= '0;
    end else if (ss_step == '0) begin
      ss_step <= SS_W'(1);
    end else if (ss_step != SS_W'(`CPPS_SS_STEPS)) begin
      if (step_cnt == STEP_W'(STEP_CYC - 1)) begin
        step_cnt <= '0;
        ss_step  <= ss_step + 1'b1;
      end else begin
        step_cnt <= step_cnt + 1'b1;
      end
    end
  end

  // Product is kept wide, then scaled by eighths
  logic [CUR_W+SS_W-1:0] ss_product;

  assign ss_product = prog_current * ss_step;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      charge_current_target <= '0;
    end else begin
      charge_current_target <= CUR_W'(ss_product /
                               (CUR_W+SS_W)'(`CPPS_SS_STEPS));
    end
  end

  // Switching period and cycle-rate decisions
  logic [PER_W-1:0]  per_cnt;
  logic              cycle_start;
  logic [BOOT_W-1:0] boot_cnt;
  logic              refresh_due;
  logic              high_req;

  assign cycle_start = per_cnt == '0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      per_cnt <= '0;
    end else if (per_cnt == PER_W'(PERIOD_CYC - 1)) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_mode <= 1'b0;
    end else if (cycle_start) begin
      if (sense.undercurrent_fall) begin
        sync_mode <= 1'b0;
      end else if (sense.undercurrent_rise) begin
        sync_mode <= 1'b1;
      end
    end
  end

  // Consecutive cycles with a sagging bootstrap; refresh clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n || refresh_due) begin
      boot_cnt <= '0;
    end else if (cycle_start) begin
      if (!sense.bootstrap_low) begin
        boot_cnt <= '0;
      end else if (boot_cnt <= BOOT_W'(`CPPS_BOOT_CYCLES)) begin
        boot_cnt <= boot_cnt + 1'b1;
      end
    end
  end

  assign refresh_due = boot_cnt > BOOT_W'(`CPPS_BOOT_CYCLES);

  // High side only starts at a cycle edge; once released it waits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      high_req <= 1'b0;
    end else if (!charge_ok || !sense.error_above_ramp || refresh_due) begin
      // Refresh re-arms at the next period so the frequency stays fixed
      high_req <= 1'b0;
    end else if (cycle_start) begin
      high_req <= 1'b1;
    end
  end

  // Gate sequencer
  cpps_sw_e         sw_state;
  logic [4:0]       sw_cnt;
  logic             high_on;
  logic             low_on;
  logic             pulse_only;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_state   <= CPPS_SW_IDLE;
      sw_cnt     <= '0;
      pulse_only <= 1'b0;
    end else begin
      case (sw_state)
        CPPS_SW_IDLE: begin
          sw_cnt <= '0;
          if (high_req) begin
            sw_state <= CPPS_SW_DEAD_HIGH;
          end
        end
        CPPS_SW_DEAD_HIGH: begin
          if (sw_cnt == 5'(DEAD_CYC - 1)) begin
            sw_state <= CPPS_SW_HIGH;
            sw_cnt   <= '0;
          end else begin
            sw_cnt <= sw_cnt + 1'b1;
          end
        end
        CPPS_SW_HIGH: begin
          sw_cnt <= '0;
          if (!high_req || refresh_due) begin
            sw_state   <= CPPS_SW_DEAD_LOW;
            pulse_only <= !sync_mode || refresh_due;
          end
        end
        CPPS_SW_DEAD_LOW: begin
          if (sw_cnt == 5'(DEAD_CYC - 1)) begin
            sw_state <= CPPS_SW_LOW;
            sw_cnt   <= '0;
          end else begin
            sw_cnt <= sw_cnt + 1'b1;
          end
        end
        CPPS_SW_LOW: begin
          if (pulse_only) begin
            if (sw_cnt == 5'(REFRESH_CYC - 1)) begin
              sw_state <= CPPS_SW_IDLE;
              sw_cnt   <= '0;
            end else begin
              sw_cnt <= sw_cnt + 1'b1;
            end
          end else if (high_req) begin
            sw_state <= CPPS_SW_DEAD_HIGH;
            sw_cnt   <= '0;
          end else if (!charge_ok) begin
            sw_state <= CPPS_SW_IDLE;
          end
        end
        default: begin
          sw_state <= CPPS_SW_IDLE;
          sw_cnt   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      high_on <= 1'b0;
      low_on  <= 1'b0;
    end else begin
      high_on <= sw_state == CPPS_SW_HIGH;
      low_on  <= sw_state == CPPS_SW_LOW;
    end
  end

  // Each gate level has its own flop so the struct has one driver
  assign gates = cpps_gate_s'({adapter_on, battery_on, high_on, low_on});

  // Read port: data stands only in the cycle after the strobe
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[`CPPS_ST_CHARGE]   = charge_enable;
    status_word[`CPPS_ST_ADAPTER]  = gates.adapter_switch_gate;
    status_word[`CPPS_ST_BATTERY]  = gates.battery_switch_gate;
    status_word[`CPPS_ST_SYNC]     = sync_mode;
    status_word[`CPPS_ST_DETECTED] = detect_done;
    status_word[`CPPS_ST_STEP_LO +: SS_W] = ss_step;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == `CPPS_CTRL_OFS) begin
      reg_rdata <= 32'(prog_current);
    end else if (reg_addr == `CPPS_STATUS_OFS) begin
      reg_rdata <= status_word;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : cpps_top

`default_nettype wire

// ===== hdl/cpps_params.svh
`ifndef CPPS_PARAMS_SVH
`define CPPS_PARAMS_SVH

// Clock rate
`define CPPS_CLK_MHZ        200

// Times in their own units
`define CPPS_DETECT_MS      700
`define CPPS_INRUSH_MS      10
`define CPPS_STEP_MS        1
`define CPPS_BBM_US         10
`define CPPS_PWM_KHZ        300
`define CPPS_DEAD_NS        30
`define CPPS_REFRESH_NS     80

// Counts
`define CPPS_SS_STEPS       8
`define CPPS_BOOT_CYCLES    3
`define CPPS_SYNC_STAGES    2

// Register map
`define CPPS_ADDR_W         8
`define CPPS_CTRL_OFS       8'h00
`define CPPS_STATUS_OFS     8'h04
`define CPPS_CTRL_RST       8'hff

// Status field positions
`define CPPS_ST_CHARGE      0
`define CPPS_ST_ADAPTER     1
`define CPPS_ST_BATTERY     2
`define CPPS_ST_SYNC        3
`define CPPS_ST_DETECTED    4
`define CPPS_ST_STEP_LO     8

`endif

// ===== hdl/cpps_pkg.sv
package cpps_pkg;

  // Comparator and host levels, all asynchronous to core_clk
  typedef struct packed {
    logic charge_inhibit_n;
    logic supply_above_lockout;
    logic adapter_detect;
    logic adapter_above_cell;
    logic input_overvoltage_flag;
    logic regulators_ready;
    logic thermal_shutdown_flag;
    logic thermistor_in_window;
    logic ratio_reference_ok;
    logic learn_request;
    logic cell_stack_low;
    logic bootstrap_low;
    logic undercurrent_fall;
    logic undercurrent_rise;
    logic error_above_ramp;
  } cpps_sense_s;

  // Gate commands: 1 holds the gate 6 V below its rail, 0 pulls it to rail
  typedef struct packed {
    logic adapter_switch_gate;
    logic battery_switch_gate;
    logic high_side_gate;
    logic low_side_gate;
  } cpps_gate_s;

  typedef enum logic [1:0] {
    CPPS_SEL_BATTERY,
    CPPS_SEL_BREAK_TO_ADAPTER,
    CPPS_SEL_ADAPTER,
    CPPS_SEL_BREAK_TO_BATTERY
  } cpps_sel_e;

  typedef enum logic [2:0] {
    CPPS_SW_IDLE,
    CPPS_SW_DEAD_HIGH,
    CPPS_SW_HIGH,
    CPPS_SW_DEAD_LOW,
    CPPS_SW_LOW
  } cpps_sw_e;

endpackage : cpps_pkg

// ===== verif/cpps_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cpps_sva
  import cpps_pkg::*;
#(
  parameter int CUR_W = 8
) (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire cpps_sense_s      sense_pins,
  input wire cpps_gate_s       gates,
  input wire logic             charge_enable,
  input wire logic [CUR_W-1:0] charge_current_target,
  input wire logic             sync_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  int   off_cnt;
  int   hi_gap;
  logic hi_seen;

  // Cycles with both selector switches off
  always_ff @(posedge core_clk) begin
    if (!rst_n || gates.adapter_switch_gate || gates.battery_switch_gate) begin
      off_cnt <= 0;
    end else begin
      off_cnt <= off_cnt + 1;
    end
  end

  // Period measure; skipped periods allowed for low duty
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hi_gap  <= 0;
      hi_seen <= 1'b0;
    end else if ($rose(gates.high_side_gate)) begin
      hi_gap  <= 1;
      hi_seen <= 1'b1;
    end else begin
      hi_gap <= hi_gap + 1;
    end
  end

  sel_excl_a: assert property (
    !(gates.adapter_switch_gate && gates.battery_switch_gate))
    else $error("both selector switches on");
  bbm_adapter_a: assert property (
    $rose(gates.adapter_switch_gate) |-> off_cnt >= 2000)
    else $error("adapter switch closed without break");
  bbm_battery_a: assert property (
    $rose(gates.battery_switch_gate) |-> off_cnt >= 2000)
    else $error("battery switch closed without break");
  inhibit_stop_a: assert property (
    $rose(sense_pins.charge_inhibit_n) |-> ##[1:5] !charge_enable)
    else $error("charging kept while inhibited");
  learn_stop_a: assert property (
    $rose(sense_pins.learn_request) && !sense_pins.cell_stack_low
    |-> ##[1:6] !(charge_enable || gates.adapter_switch_gate))
    else $error("learn did not override");
  ovp_stop_a: assert property (
    $rose(sense_pins.input_overvoltage_flag)
    |-> ##[1:6] !(charge_enable || gates.adapter_switch_gate))
    else $error("overvoltage did not stop");
  target_zero_a: assert property (
    !charge_enable && !$past(charge_enable) |-> charge_current_target == '0)
    else $error("target held while not charging");
  buck_excl_a: assert property (
    !(gates.high_side_gate && gates.low_side_gate))
    else $error("both buck gates on");
  dead_time_a: assert property (
    $fell(gates.high_side_gate) |-> !gates.low_side_gate [*6])
    else $error("low side on inside dead time");
  refresh_len_a: assert property (
    $rose(gates.low_side_gate) && !sync_mode |-> gates.low_side_gate [*8]
    ##8 (gates.low_side_gate ##1 !gates.low_side_gate))
    else $error("low side pulse length wrong");
  fixed_period_a: assert property (
    $rose(gates.high_side_gate) && hi_seen |-> hi_gap % 666 == 0)
    else $error("switching period off grid");

  cover property ($rose(gates.adapter_switch_gate));
  cover property ($rose(charge_enable));
  cover property ($rose(gates.low_side_gate) && !sync_mode);
endmodule : cpps_sva

bind cpps_top cpps_sva #(.CUR_W(CUR_W)) u_sva (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .sense_pins(sense_pins),
  .gates(gates),
  .charge_enable(charge_enable),
  .charge_current_target(charge_current_target),
  .sync_mode(sync_mode)
);
`default_nettype wire

// ===== verif/cpps_partner.sv
`timescale 1ns/10ps
`default_nettype none
module cpps_partner
  import cpps_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire cpps_sense_s host,
  input  wire logic        plugged,
  input  wire logic [9:0]  err_lvl,
  output cpps_sense_s      sense_pins
);
  logic [9:0] ramp;
  logic [6:0] sag;

  // Sawtooth leads the switching count by the two synchroniser cycles
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ramp <= 10'h002;
    end else if (ramp == 10'h299) begin
      ramp <= '0;
    end else begin
      ramp <= ramp + 10'h001;
    end
  end

  // System caps hold the rail up for a while after unplug
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sag <= '0;
    end else if (plugged) begin
      sag <= 7'h64;
    end else if (sag != '0) begin
      sag <= sag - 7'h01;
    end
  end

  always_comb begin
    sense_pins                    = host;
    sense_pins.adapter_detect     = plugged;
    sense_pins.adapter_above_cell = plugged || sag != '0;
    sense_pins.error_above_ramp   = err_lvl > ramp;
  end
endmodule : cpps_partner
`default_nettype wire

// ===== verif/cpps_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cpps_tb_top;
  import cpps_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        plugged  = 1'b0;
  logic [9:0]  err_lvl  = '0;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr   = 1'b0;
  logic        reg_rd   = 1'b0;
  logic [31:0] reg_rdata;
  cpps_sense_s host;
  cpps_sense_s sense_pins;
  cpps_gate_s  gates;
  logic        charge_enable;
  logic        sync_mode;
  logic [7:0]  charge_current_target;
  logic [7:0]  tgt_exp;
  int          err_total;
  int          comparisons;
  int          bad [5] = '{8, 7, 6, 9, 13};

  always #2.5 core_clk = ~core_clk;

  cpps_partner u_far (.core_clk(core_clk), .rst_n(rst_n), .host(host),
    .plugged(plugged), .err_lvl(err_lvl), .sense_pins(sense_pins));
  cpps_top #(.DETECT_CYC(200), .INRUSH_CYC(20), .STEP_CYC(50)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .sense_pins(sense_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gates(gates),
    .charge_enable(charge_enable),
    .charge_current_target(charge_current_target), .sync_mode(sync_mode));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic obs(input int k);
    case (k)
      0: obs = charge_enable;
      1: obs = gates.adapter_switch_gate;
      2: obs = gates.battery_switch_gate;
      3: obs = gates.low_side_gate;
      4: obs = sync_mode;
      5: obs = gates.high_side_gate;
      default: obs = charge_current_target === tgt_exp;
    endcase
  endfunction : obs

  // Bounded wait; a timeout ends the run
  task automatic wt(input int k, input logic v, input int n);
    for (int i = 0; i < n && obs(k) !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    comparisons++;
    if (obs(k) !== v) begin
      err_total++;
      $display("Error %0t: wait on %0d timed out", $time, k);
      conclude();
    end
  endtask : wt

  task automatic hold(input int k, input logic v, input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      chk(32'(obs(k)), 32'(v));
    end
  endtask : hold

  task automatic pin(input int b, input logic v);
    @(posedge core_clk);
    host[b] <= v;
  endtask : pin

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  initial begin
    host        = 15'h22c2;
    err_total   = 0;
    comparisons = 0;
    tgt_exp     = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(32'(gates), 32'h0000_0004);
    chk(32'({charge_enable, sync_mode, charge_current_target}), 32'h0);
    rd(8'h00, 32'h0000_00ff);
    rd(8'h04, 32'h0000_0004);
    wr(8'h10, 32'h0000_0012);
    rd(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_0040);
    rd(8'h00, 32'h0000_0040);
    $display("test reset done");
    @(posedge core_clk);
    plugged <= 1'b1;
    hold(0, 1'b0, 210);
    wt(0, 1'b1, 30);
    for (int s = 1; s <= 8; s++) begin
      tgt_exp = 8'(8 * s);
      wt(6, 1'b1, 60);
    end
    wt(1, 1'b1, 2100);
    rd(8'h04, 32'h0000_081b);
    $display("test insert done");
    pin(14, 1'b1);
    wt(0, 1'b0, 8);
    tgt_exp = '0;
    wt(6, 1'b1, 4);
    pin(14, 1'b0);
    tgt_exp = 8'h08;
    wt(6, 1'b1, 12);
    foreach (bad[i]) begin
      pin(bad[i], ~host[bad[i]]);
      wt(0, 1'b0, 8);
      pin(bad[i], ~host[bad[i]]);
      wt(0, 1'b1, 12);
    end
    $display("test enable done");
    hold(5, 1'b0, 1400);
    @(posedge core_clk);
    err_lvl <= 10'h14d;
    wt(5, 1'b1, 700);
    pin(1, 1'b0);
    pin(2, 1'b1);
    wt(4, 1'b0, 1400);
    wt(3, 1'b1, 700);
    pin(2, 1'b0);
    hold(4, 1'b0, 1400);
    pin(1, 1'b1);
    wt(4, 1'b1, 1400);
    @(posedge core_clk);
    err_lvl <= 10'h3ff;
    repeat (1400) @(posedge core_clk);
    hold(3, 1'b0, 666);
    pin(3, 1'b1);
    wt(3, 1'b1, 3400);
    pin(3, 1'b0);
    $display("test buck done");
    pin(5, 1'b1);
    wt(1, 1'b0, 8);
    wt(0, 1'b0, 8);
    wt(2, 1'b1, 2100);
    pin(4, 1'b1);
    wt(1, 1'b1, 2200);
    pin(4, 1'b0);
    wt(2, 1'b1, 2200);
    pin(5, 1'b0);
    wt(1, 1'b1, 2200);
    pin(10, 1'b1);
    wt(1, 1'b0, 8);
    wt(2, 1'b1, 2100);
    pin(10, 1'b0);
    wt(1, 1'b1, 2200);
    $display("test override done");
    @(posedge core_clk);
    plugged <= 1'b0;
    hold(1, 1'b1, 60);
    wt(1, 1'b0, 60);
    wt(2, 1'b1, 2100);
    wt(0, 1'b0, 10);
    $display("test removal done");
    conclude();
  end
endmodule : cpps_tb_top
`default_nettype wire
